/* File: hw/gpb_pkg.sv */
// How it works
// - eight separate pullup enables for first port
// - pullup acts only on input pins
// - output direction forces pullup off at once
// - enable bit one connects pullup, zero disconnects
// - keyboard pins pick pullup or pulldown by polarity
// - second port eight latched pins, all analog capable
// - reset keeps second port data latches
// - analog channel select overrides second port pin
// - second port direction one drives, zero inputs
// - reset makes all second port pins inputs
// - second port read: latch if output, pin otherwise
// - data latches always writable, whatever the direction
// - write to input pin leaves pin reading alone
// - third port seven pins, top bit unimplemented
// - third port low pins serve can when enabled
// - reset keeps third port data latches
// - third port direction one drives, reset clears all
// - third port read: latch if output, pin otherwise
// - reset makes all third port pins inputs
// - first port direction one drives, gates pullups
package gpb_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int         ADDR_W              = 8;
    localparam logic [7:0] ADDR_SECOND_DATA    = 8'h01;
    localparam logic [7:0] ADDR_THIRD_DATA     = 8'h02;
    localparam logic [7:0] ADDR_FIRST_DIR      = 8'h04;
    localparam logic [7:0] ADDR_SECOND_DIR     = 8'h05;
    localparam logic [7:0] ADDR_THIRD_DIR      = 8'h06;
    localparam logic [7:0] ADDR_FIRST_PULLUP   = 8'h0D;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int         THIRD_W             = 7;
    localparam int         CAN_RX_BIT          = 1;
    localparam int         CAN_TX_BIT          = 0;
    localparam logic       THIRD_TOP_READ      = 1'b1;
    localparam logic [7:0] DIR_RESET           = 8'h00;
    localparam logic [7:0] PULLUP_RESET        = 8'h00;
    localparam logic [7:0] UNMAPPED_READ       = 8'h00;

    // ****************************************************************
    // analog channel numbering of the second port
    // ****************************************************************
    localparam int         ADC_CH_W            = 5;
    localparam logic [4:0] ADC_SECOND_FIRST_CH = 5'h00;
    localparam logic [4:0] ADC_SECOND_LAST_CH  = 5'h07;

    // ****************************************************************
    // synchroniser depth
    // ****************************************************************
    localparam int         SYNC_STAGES         = 2;

endpackage

/* File: hw/gpb_sync.sv */
// ****************************************************************
// two-stage level synchroniser for pin inputs
// ****************************************************************
module gpb_sync
    import gpb_pkg::*;
#(
    parameter int WIDTH = 15
) (
    input  wire logic             sys_clk, // bus clock
    input  wire logic             rst_n,   // sync reset, active low
    input  wire logic [WIDTH-1:0] level_in, // raw pin levels
    output logic      [WIDTH-1:0] level_out // synchronised levels
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpb_sync_state_type;

    gpb_sync_state_type state_reg;
    gpb_sync_state_type state_next;

    // first stage feeds only the second stage
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = level_in;
        state_next.stage2 = state_reg.stage1;
        if (!rst_n) begin
            state_next = '0;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign level_out = state_reg.stage2;

endmodule

/* File: hw/gpb_ports.sv */
// ****************************************************************
// gpio ports: first port pullups, second and third port logic
// ****************************************************************
//
// Design decision made here: the address-and-strobe port.
module gpb_ports
    import gpb_pkg::*;
(
    input  wire logic              sys_clk,        // bus clock, 40 MHz
    input  wire logic              rst_n,          // sync reset
    input  wire logic [ADDR_W-1:0] addr,           // register address
    input  wire logic [7:0]        wr_data,        // write data
    input  wire logic              wr_en,          // write strobe
    input  wire logic              rd_en,          // read strobe
    output logic      [7:0]        rd_data,        // read data, next cycle
    input  wire logic [7:0]        kbd_pin_enable, // keyboard pins in use
    input  wire logic [7:0]        keyboard_polarity_select, // 1 = rising
    input  wire logic              adc_enable,     // converter active
    input  wire logic [ADC_CH_W-1:0] adc_channel,  // channel select
    output logic      [7:0]        analog_input_pins, // analog switches
    output logic      [7:0]        first_port_direction, // to pad logic
    output logic      [7:0]        first_port_pullup_on,   // pullups
    output logic      [7:0]        first_port_pulldown_on, // pulldowns
    input  wire logic [7:0]        second_pin_in,  // second port pins
    output logic      [7:0]        second_pin_out, // pin drive value
    output logic      [7:0]        second_pin_oe,  // pin drive enable
    input  wire logic [THIRD_W-1:0] third_pin_in,  // third port pins
    output logic      [THIRD_W-1:0] third_pin_out, // pin drive value
    output logic      [THIRD_W-1:0] third_pin_oe,  // pin drive enable
    input  wire logic              can_pin_enable,   // can owns low pins
    input  wire logic              can_transmit_pin, // can tx level
    output logic                   can_receive_pin   // can rx level
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]         first_dir;
        logic [7:0]         first_pue;
        logic [7:0]         second_data;
        logic [7:0]         second_dir;
        logic [THIRD_W-1:0] third_data;
        logic [THIRD_W-1:0] third_dir;
        logic [7:0]         rd_data;
        logic [7:0]         analog_sel;
        logic [7:0]         pullup_on;
        logic [7:0]         pulldown_on;
        logic [7:0]         second_out;
        logic [7:0]         second_oe;
        logic [THIRD_W-1:0] third_out;
        logic [THIRD_W-1:0] third_oe;
        logic               can_rx;
    } gpb_ports_state_type;

    gpb_ports_state_type state_reg;
    gpb_ports_state_type state_next;

    // synchronised pin levels
    logic [7:0]         second_level;
    logic [THIRD_W-1:0] third_level;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // per pin: latch when driven, pin level when input
    function automatic logic [7:0] pin_view(
        input logic [7:0] latch,
        input logic [7:0] level,
        input logic [7:0] dir
    );
        pin_view = (latch & dir) | (level & ~dir);
    endfunction

    // one-hot select of a second port pin from the channel number
    function automatic logic [7:0] analog_decode(
        input logic                en,
        input logic [ADC_CH_W-1:0] ch
    );
        logic [ADC_CH_W-1:0] rel;
        analog_decode = 8'h00;
        rel           = ch - ADC_SECOND_FIRST_CH;
        if (en && ch >= ADC_SECOND_FIRST_CH
               && ch <= ADC_SECOND_LAST_CH) begin
            analog_decode[rel[2:0]] = 1'b1;
        end
    endfunction

    // ****************************************************************
    // input synchroniser
    // ****************************************************************

    gpb_sync #(
        .WIDTH (8 + THIRD_W)
    ) u_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  ({third_pin_in, second_pin_in}),
        .level_out ({third_level, second_level})
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [7:0]         analog_now;
        logic [7:0]         third_view;
        logic [7:0]         third_full;
        logic [7:0]         resistor_on;
        logic [THIRD_W-1:0] can_mask;

        state_next  = state_reg;
        analog_now  = analog_decode(adc_enable, adc_channel);
        third_view  = 8'h00;
        third_full  = 8'h00;
        resistor_on = 8'h00;
        can_mask    = '0;

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_en) begin
            unique case (addr)
                ADDR_FIRST_DIR: begin
                    state_next.first_dir = wr_data;
                end
                ADDR_FIRST_PULLUP: begin
                    state_next.first_pue = wr_data;
                end
                ADDR_SECOND_DATA: begin
                    state_next.second_data = wr_data;
                end
                ADDR_SECOND_DIR: begin
                    state_next.second_dir = wr_data;
                end
                // third latch written whatever the direction
                ADDR_THIRD_DATA: begin
                    state_next.third_data = wr_data[THIRD_W-1:0];
                end
                ADDR_THIRD_DIR: begin
                    state_next.third_dir = wr_data[THIRD_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // register reads, data valid one cycle after the strobe
        // ------------------------------------------------------------
        third_full = pin_view({1'b0, state_reg.third_data},
                              {1'b0, third_level},
                              {1'b0, state_reg.third_dir});
        third_view[THIRD_W-1:0] = third_full[THIRD_W-1:0];
        // unimplemented top bit reads as one
        third_view[7] = THIRD_TOP_READ;

        state_next.rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                ADDR_FIRST_DIR: begin
                    state_next.rd_data = state_reg.first_dir;
                end
                ADDR_FIRST_PULLUP: begin
                    state_next.rd_data = state_reg.first_pue;
                end
                // latch for outputs, pin for inputs
                ADDR_SECOND_DATA: begin
                    state_next.rd_data = pin_view(state_reg.second_data,
                                                  second_level,
                                                  state_reg.second_dir);
                end
                ADDR_SECOND_DIR: begin
                    state_next.rd_data = state_reg.second_dir;
                end
                // latch for outputs, pin for inputs
                ADDR_THIRD_DATA: begin
                    state_next.rd_data = third_view;
                end
                ADDR_THIRD_DIR: begin
                    state_next.rd_data = {1'b0, state_reg.third_dir};
                end
                default: begin
                    state_next.rd_data = UNMAPPED_READ;
                end
            endcase
        end

        // ------------------------------------------------------------
        // first port pull resistors, one per pin
        // ------------------------------------------------------------
        for (int i = 0; i < 8; i++) begin
            resistor_on[i] = state_next.first_pue[i]
                           & ~state_next.first_dir[i];
            if (kbd_pin_enable[i] && keyboard_polarity_select[i]) begin
                state_next.pullup_on[i]   = 1'b0;
                state_next.pulldown_on[i] = resistor_on[i];
            end else begin
                state_next.pullup_on[i]   = resistor_on[i];
                state_next.pulldown_on[i] = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // second port pins
        // ------------------------------------------------------------
        // analog select removes the digital driver
        state_next.analog_sel = analog_now;
        // buffer on where direction is one
        state_next.second_oe  = state_next.second_dir & ~analog_now;
        state_next.second_out = state_next.second_data
                              & state_next.second_dir
                              & ~analog_now;

        // ------------------------------------------------------------
        // third port pins
        // ------------------------------------------------------------
        // can controller owns the two low pins
        if (can_pin_enable) begin
            can_mask[CAN_RX_BIT] = 1'b1;
            can_mask[CAN_TX_BIT] = 1'b1;
        end
        state_next.third_oe  = state_next.third_dir & ~can_mask;
        state_next.third_out = state_next.third_data
                             & state_next.third_dir
                             & ~can_mask;
        if (can_pin_enable) begin
            state_next.third_oe[CAN_TX_BIT]  = 1'b1;
            state_next.third_out[CAN_TX_BIT] = can_transmit_pin;
        end
        state_next.can_rx = can_pin_enable
                          ? third_level[CAN_RX_BIT]
                          : 1'b1;

        // ------------------------------------------------------------
        // synchronous reset
        // ------------------------------------------------------------
        if (!rst_n) begin
            state_next.second_data = state_reg.second_data;
            state_next.third_data  = state_reg.third_data;
            state_next.second_dir  = DIR_RESET;
            state_next.third_dir   = DIR_RESET[THIRD_W-1:0];
            state_next.first_dir   = DIR_RESET;
            state_next.first_pue   = PULLUP_RESET;
            state_next.rd_data     = 8'h00;
            state_next.analog_sel  = 8'h00;
            state_next.pullup_on   = 8'h00;
            state_next.pulldown_on = 8'h00;
            state_next.second_out  = 8'h00;
            state_next.second_oe   = 8'h00;
            state_next.third_out   = '0;
            state_next.third_oe    = '0;
            state_next.can_rx      = 1'b1;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign rd_data                = state_reg.rd_data;
    assign analog_input_pins      = state_reg.analog_sel;
    assign first_port_direction   = state_reg.first_dir;
    assign first_port_pullup_on   = state_reg.pullup_on;
    assign first_port_pulldown_on = state_reg.pulldown_on;
    assign second_pin_out         = state_reg.second_out;
    assign second_pin_oe          = state_reg.second_oe;
    assign third_pin_out          = state_reg.third_out;
    assign third_pin_oe           = state_reg.third_oe;
    assign can_receive_pin        = state_reg.can_rx;

endmodule

/* File: dv/gpb_ports_assertions.sv */
// ******
// port checker
// ******
module gpb_ports_checker
    import gpb_pkg::*;
(
    input wire logic                sys_clk,                  // clock
    input wire logic                rst_n,                    // reset
    input wire logic [7:0]          kbd_pin_enable,           // kbd pins
    input wire logic [7:0]          keyboard_polarity_select, // polarity
    input wire logic                adc_enable,               // adc on
    input wire logic [ADC_CH_W-1:0] adc_channel,              // channel
    input wire logic [7:0]          analog_input_pins,        // switches
    input wire logic [7:0]          first_port_direction,     // dir
    input wire logic [7:0]          first_port_pullup_on,     // pullups
    input wire logic [7:0]          first_port_pulldown_on,   // pulldowns
    input wire logic [7:0]          second_pin_out,           // drive
    input wire logic [7:0]          second_pin_oe,            // enable
    input wire logic [THIRD_W-1:0]  third_pin_in,             // levels
    input wire logic [THIRD_W-1:0]  third_pin_out,            // drive
    input wire logic [THIRD_W-1:0]  third_pin_oe,             // enable
    input wire logic                can_pin_enable,           // can owns
    input wire logic                can_transmit_pin,         // can tx
    input wire logic                can_receive_pin           // can rx
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // can ownership held for three edges
    sequence s_can_on;
        can_pin_enable ##1 can_pin_enable ##1 can_pin_enable;
    endsequence

    a_pull_exclusive: assert property (
        (first_port_pullup_on & first_port_pulldown_on) == 8'h00)
        else $error("both pulls on");
    a_pull_direction: assert property (
        ((first_port_pullup_on | first_port_pulldown_on)
        & first_port_direction) == 8'h00)
        else $error("pull on output pin");
    a_pull_polarity: assert property (
        $past(rst_n) |->
        ((first_port_pulldown_on
        & ~$past(kbd_pin_enable & keyboard_polarity_select))
        | (first_port_pullup_on
        & $past(kbd_pin_enable & keyboard_polarity_select))) == 8'h00)
        else $error("pull kind wrong");
    a_analog_select: assert property (
        $past(rst_n) |-> analog_input_pins ==
        (($past(adc_enable) && $past(adc_channel) <= ADC_SECOND_LAST_CH)
        ? (8'h01 << $past(adc_channel)) : 8'h00))
        else $error("analog switch wrong");
    a_second_masked: assert property (
        (second_pin_out & ~second_pin_oe) == 8'h00)
        else $error("drive value on undriven pin");
    a_can_tx: assert property (
        $past(rst_n) && $past(can_pin_enable) |->
        third_pin_oe[CAN_TX_BIT] && !third_pin_oe[CAN_RX_BIT]
        && third_pin_out[CAN_TX_BIT] == $past(can_transmit_pin))
        else $error("can transmit pin wrong");
    a_can_rx_follow: assert property (
        s_can_on |=> can_receive_pin == $past(third_pin_in[CAN_RX_BIT], 3))
        else $error("can receive level wrong");
    a_can_rx_idle: assert property (
        $past(rst_n) && !$past(can_pin_enable) |-> can_receive_pin)
        else $error("can receive not idle");
endmodule

bind gpb_ports gpb_ports_checker u_chk (
    .sys_clk, .rst_n, .kbd_pin_enable, .keyboard_polarity_select,
    .adc_enable, .adc_channel, .analog_input_pins, .first_port_direction,
    .first_port_pullup_on, .first_port_pulldown_on, .second_pin_out,
    .second_pin_oe, .third_pin_in, .third_pin_out, .third_pin_oe,
    .can_pin_enable, .can_transmit_pin, .can_receive_pin
);

/* File: dv/gpb_pin_model.sv */
// ******
// far side pin levels
// ******
module gpb_pin_model
    import gpb_pkg::*;
(
    input  wire logic [7:0]         second_pin_out, // drive
    input  wire logic [7:0]         second_pin_oe,  // enable
    input  wire logic [7:0]         second_ext,     // outside level
    output logic      [7:0]         second_pin_in,  // pin level
    input  wire logic [THIRD_W-1:0] third_pin_out,  // drive
    input  wire logic [THIRD_W-1:0] third_pin_oe,   // enable
    input  wire logic [THIRD_W-1:0] third_ext,      // outside level
    output logic      [THIRD_W-1:0] third_pin_in    // pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign second_pin_in = (second_pin_out & second_pin_oe)
                         | (second_ext & ~second_pin_oe);
    assign third_pin_in = (third_pin_out & third_pin_oe)
                        | (third_ext & ~third_pin_oe);
endmodule

/* File: dv/tb.sv */
// ******
// port testbench
// ******
module tb
    import gpb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk, rst_n, wr_en, rd_en, adc_enable;
    logic                can_pin_enable, can_transmit_pin, can_receive_pin;
    logic [ADDR_W-1:0]   addr;
    logic [ADC_CH_W-1:0] adc_channel;
    logic [7:0]          wr_data, rd_data, kbd_pin_enable;
    logic [7:0]          keyboard_polarity_select, analog_input_pins;
    logic [7:0]          first_port_direction, first_port_pullup_on;
    logic [7:0]          first_port_pulldown_on, second_pin_in;
    logic [7:0]          second_pin_out, second_pin_oe, second_ext;
    logic [THIRD_W-1:0]  third_pin_in, third_pin_out, third_pin_oe;
    logic [THIRD_W-1:0]  third_ext;
    logic [7:0]          lat_b, dir_b, lat_c, dir_c, pu, da, kb, pol, t8;
    int                  miscompares = 0;
    int                  comparisons = 0;
    int                  cycles = 0;
    int unsigned         seed_ret;

    gpb_ports dut (
        .sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .kbd_pin_enable, .keyboard_polarity_select, .adc_enable,
        .adc_channel, .analog_input_pins, .first_port_direction,
        .first_port_pullup_on, .first_port_pulldown_on, .second_pin_in,
        .second_pin_out, .second_pin_oe, .third_pin_in, .third_pin_out,
        .third_pin_oe, .can_pin_enable, .can_transmit_pin, .can_receive_pin
    );
    gpb_pin_model u_pins (
        .second_pin_out, .second_pin_oe, .second_ext, .second_pin_in,
        .third_pin_out, .third_pin_oe, .third_ext, .third_pin_in
    );

    // ******
    // helpers
    // ******
    function automatic logic [7:0] rnd8();
        int unsigned r;
        r = $urandom;
        return r[7:0];
    endfunction
    // latch on outputs, pin on inputs
    function automatic logic [7:0] port_rd(logic [7:0] l, logic [7:0] d,
                                           logic [7:0] p);
        return (l & d) | (p & ~d);
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        comparisons++;
        if (e !== a) begin
            miscompares++;
            $display("mismatch at %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(e, rd_data);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ******
    // scenarios
    // ******
    initial begin
        rst_n = 1'b0;
        {wr_en, rd_en, adc_enable, can_pin_enable, can_transmit_pin} = '0;
        {addr, wr_data, kbd_pin_enable, keyboard_polarity_select} = '0;
        {adc_channel, second_ext, third_ext} = '0;
        seed_ret = $urandom(32'h5701b847);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_FIRST_DIR, DIR_RESET);       // reset value
        rd_chk(ADDR_SECOND_DIR, DIR_RESET);      // reset value
        rd_chk(ADDR_THIRD_DIR, DIR_RESET);       // reset value
        rd_chk(ADDR_FIRST_PULLUP, PULLUP_RESET); // reset value
        bus_wr(8'h07, 8'hA5);
        rd_chk(8'h07, UNMAPPED_READ);            // unmapped read
        for (int i = 0; i < 40; i++) begin
            lat_b = rnd8();
            dir_b = (i < 2) ? {8{i[0]}} : rnd8();
            lat_c = rnd8();
            dir_c = rnd8();
            t8 = rnd8();
            @(posedge sys_clk);
            second_ext <= rnd8();
            third_ext  <= t8[6:0];
            bus_wr(ADDR_SECOND_DATA, lat_b); // latch first
            bus_wr(ADDR_SECOND_DIR, dir_b);  // direction
            bus_wr(ADDR_THIRD_DATA, lat_c);  // latch first
            bus_wr(ADDR_THIRD_DIR, dir_c);   // direction
            cyc(3);
            chk(dir_b, second_pin_oe);                     // enable
            chk(lat_b & dir_b, second_pin_out);            // value
            chk({1'b0, dir_c[6:0]}, {1'b0, third_pin_oe}); // enable
            chk({1'b0, lat_c[6:0] & dir_c[6:0]}, {1'b0, third_pin_out});
            t8 = port_rd(lat_b, dir_b, second_ext);
            rd_chk(ADDR_SECOND_DATA, t8);                // read
            t8 = port_rd(lat_c, dir_c, {1'b0, third_ext});
            rd_chk(ADDR_THIRD_DATA, {THIRD_TOP_READ, t8[6:0]});
            rd_chk(ADDR_THIRD_DIR, {1'b0, dir_c[6:0]});
        end
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_SECOND_DIR, DIR_RESET); // cleared
        rd_chk(ADDR_THIRD_DIR, DIR_RESET);  // cleared
        bus_wr(ADDR_SECOND_DIR, 8'hFF);
        bus_wr(ADDR_THIRD_DIR, 8'h7F);
        rd_chk(ADDR_SECOND_DATA, lat_b);                       // kept
        rd_chk(ADDR_THIRD_DATA, {THIRD_TOP_READ, lat_c[6:0]}); // kept
        for (int i = 0; i < 9; i++) begin
            t8 = (i < 8) ? 8'h01 << i : 8'h00;
            @(posedge sys_clk);
            adc_enable  <= 1'b1;
            adc_channel <= i[ADC_CH_W-1:0];
            cyc(2);
            chk(t8, analog_input_pins); // switch
            chk(~t8, second_pin_oe);    // buffer off
        end
        @(posedge sys_clk);
        adc_enable <= 1'b0;
        for (int j = 0; j < 24; j++) begin
            pu = (j < 2) ? 8'hFF : rnd8();
            da = (j < 2) ? {8{j[0]}} : rnd8();
            kb = (j < 8) ? 8'h00 : rnd8();
            pol = rnd8();
            @(posedge sys_clk);
            kbd_pin_enable           <= kb;
            keyboard_polarity_select <= pol;
            bus_wr(ADDR_FIRST_PULLUP, pu); // enables
            bus_wr(ADDR_FIRST_DIR, da);    // direction
            cyc(2);
            chk(da, first_port_direction);                     // copy
            chk(pu & ~da & ~(kb & pol), first_port_pullup_on);
            chk(pu & ~da & kb & pol, first_port_pulldown_on);  // pulls
            rd_chk(ADDR_FIRST_PULLUP, pu);                     // read
        end
        // can owns the two low pins
        @(posedge sys_clk);
        can_pin_enable <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            can_transmit_pin <= k[0];
            third_ext        <= {5'h00, ~k[0], 1'b0};
            cyc(5);
            chk({4'h0, 2'b10, k[0], ~k[0]}, {4'h0, third_pin_oe[0],
                third_pin_oe[1], third_pin_out[0], can_receive_pin});
        end
        @(posedge sys_clk);
        can_pin_enable <= 1'b0;
        cyc(2);
        chk(8'h01, {7'h00, can_receive_pin}); // idle high
        chk(8'h7F, {1'b0, third_pin_oe});     // gpio back
        give_verdict();
    end
endmodule
